//--- logic/sfrl_pkg.sv
// constants, carriers and decode helpers for the serial flash host controller
// assumes an APB master on the register side and one flash device on the lane side
// Operation
// - plain/fast/dual-out/quad-out reads: Cx is 7, 3 or 1 plus bits/1, /2, /4
// - dual io read: Cx is 7 or 3 plus half the address bits
// - quad io read: Cx is 7 or 1 plus a quarter of address bits
// - quad io word read counts clocks like the quad io read
// - double rate fast reads: Cx is 7, 3, 1 plus bits/2, /4, /8
// - double rate dual io read: Cx is 7 plus bits/4, or 3 plus bits/8
// - double rate quad io read: Cx is 7 or 1 plus an eighth of bits
// - write enable/disable frame: select low for eight opcode bits, then high
// - write enable/disable opcode goes on lane 0, lanes 1:0 or lanes 3:0
// - under a protection error write disable keeps the latch set
// - register reads: extended in lane 0 out lane 1; dual/quad share lanes
// - host should poll progress bits before other commands during writes
package sfrl_pkg;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] SFRL_OFF_CTRL = 8'h00;
	localparam logic [7:0] SFRL_OFF_ADDR = 8'h04;
	localparam logic [7:0] SFRL_OFF_STAT = 8'h08;
	localparam logic [7:0] SFRL_OFF_RX = 8'h0c;
	localparam int SFRL_CTRL_OP_LSB = 0;
	localparam int SFRL_CTRL_PW_LSB = 8;
	localparam int SFRL_CTRL_A4_BIT = 10;
	localparam int SFRL_CTRL_DUM_LSB = 12;
	localparam int SFRL_CTRL_NB_LSB = 16;
	localparam int SFRL_CTRL_GO_BIT = 31;
	localparam int SFRL_STAT_CX_LSB = 8;
	localparam logic [31:0] SFRL_CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] SFRL_ADDR_RST = 32'h0000_0000;

	// ----------------------------------------
	// timing and frame figures
	// ----------------------------------------
	localparam int SFRL_HALF_CYC = 4;
	localparam int SFRL_CS_HIGH_CYC = 8;
	localparam logic [7:0] SFRL_ABITS_3B = 8'h18;
	localparam logic [7:0] SFRL_ABITS_4B = 8'h20;
	localparam logic [7:0] SFRL_CX_EXT = 8'h07;
	localparam logic [7:0] SFRL_CX_DUAL = 8'h03;
	localparam logic [7:0] SFRL_CX_QUAD = 8'h01;
	localparam logic [1:0] SFRL_PW_EXT = 2'h0;
	localparam logic [1:0] SFRL_PW_DUAL = 2'h1;
	localparam logic [1:0] SFRL_PW_QUAD = 2'h2;

	// ----------------------------------------
	// opcodes
	// ----------------------------------------
	localparam logic [7:0] SFRL_OP_READ = 8'h03, SFRL_OP_READ4 = 8'h13;
	localparam logic [7:0] SFRL_OP_FAST = 8'h0b, SFRL_OP_FAST4 = 8'h0c;
	localparam logic [7:0] SFRL_OP_DOUT = 8'h3b, SFRL_OP_DOUT4 = 8'h3c;
	localparam logic [7:0] SFRL_OP_QOUT = 8'h6b, SFRL_OP_QOUT4 = 8'h6c;
	localparam logic [7:0] SFRL_OP_DIO = 8'hbb, SFRL_OP_DIO4 = 8'hbc;
	localparam logic [7:0] SFRL_OP_QIO = 8'heb, SFRL_OP_QIO4 = 8'hec;
	localparam logic [7:0] SFRL_OP_QWORD = 8'he7;
	localparam logic [7:0] SFRL_OP_DFAST = 8'h0d, SFRL_OP_DFAST4 = 8'h0e;
	localparam logic [7:0] SFRL_OP_DDOUT = 8'h3d, SFRL_OP_DQOUT = 8'h6d;
	localparam logic [7:0] SFRL_OP_DDIO = 8'hbd, SFRL_OP_DDIO4 = 8'hbe;
	localparam logic [7:0] SFRL_OP_DQIO = 8'hed, SFRL_OP_DQIO4 = 8'hee;
	localparam logic [7:0] SFRL_OP_WEN = 8'h06, SFRL_OP_WDIS = 8'h04;
	localparam logic [7:0] SFRL_OP_RSTAT = 8'h05, SFRL_OP_RFLAG = 8'h70;
	localparam logic [7:0] SFRL_OP_RNVCFG = 8'hb5, SFRL_OP_RVCFG = 8'h85;
	localparam logic [7:0] SFRL_OP_REVCFG = 8'h65, SFRL_OP_REXTA = 8'hc8;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic ok;
		logic dtr;
		logic has_addr;
		logic [1:0] aw;
		logic [1:0] dw;
	} sfrl_cmd_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} sfrl_apb_req_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} sfrl_apb_rsp_t;

	typedef struct packed {
		logic [7:0] op;
		logic [1:0] pw;
		logic a4;
		logic [3:0] dummy;
		logic [2:0] nb;
		logic [31:0] addr;
	} sfrl_order_t;

	typedef struct packed {
		logic busy;
		logic done;
		logic refused;
		logic [7:0] cx;
	} sfrl_stat_t;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// aw/dw hold log2 of the lane count used for address and data
	function automatic sfrl_cmd_t sfrl_decode(input logic [7:0] op, input logic [1:0] pw);
		sfrl_cmd_t c;
		c = '{ok: 1'b1, dtr: 1'b0, has_addr: 1'b1, aw: pw, dw: pw};
		case (op)
		SFRL_OP_READ, SFRL_OP_READ4, SFRL_OP_FAST, SFRL_OP_FAST4: c.ok = 1'b1;
		SFRL_OP_DOUT, SFRL_OP_DOUT4: begin
			c.dw = 2'h1;
			c.ok = (pw != SFRL_PW_QUAD);
		end
		SFRL_OP_QOUT, SFRL_OP_QOUT4: begin
			c.dw = 2'h2;
			c.ok = (pw != SFRL_PW_DUAL);
		end
		SFRL_OP_DIO, SFRL_OP_DIO4: begin
			c.aw = 2'h1;
			c.dw = 2'h1;
			c.ok = (pw != SFRL_PW_QUAD);
		end
		SFRL_OP_QIO, SFRL_OP_QIO4, SFRL_OP_QWORD: begin
			c.aw = 2'h2;
			c.dw = 2'h2;
			c.ok = (pw != SFRL_PW_DUAL);
		end
		SFRL_OP_DFAST, SFRL_OP_DFAST4: c.dtr = 1'b1;
		SFRL_OP_DDOUT: begin
			c.dtr = 1'b1;
			c.dw = 2'h1;
			c.ok = (pw != SFRL_PW_QUAD);
		end
		SFRL_OP_DQOUT: begin
			c.dtr = 1'b1;
			c.dw = 2'h2;
			c.ok = (pw != SFRL_PW_DUAL);
		end
		SFRL_OP_DDIO, SFRL_OP_DDIO4: begin
			c.dtr = 1'b1;
			c.aw = (pw == SFRL_PW_DUAL) ? 2'h2 : 2'h1;
			c.dw = 2'h1;
			c.ok = (pw != SFRL_PW_QUAD);
		end
		SFRL_OP_DQIO, SFRL_OP_DQIO4: begin
			c.dtr = 1'b1;
			c.aw = 2'h2;
			c.dw = 2'h2;
			c.ok = (pw != SFRL_PW_DUAL);
		end
		// status reads and write disable go out as plain frames; software owns the latch state
		SFRL_OP_WEN, SFRL_OP_WDIS, SFRL_OP_RSTAT, SFRL_OP_RFLAG,
		SFRL_OP_RNVCFG, SFRL_OP_RVCFG, SFRL_OP_REVCFG, SFRL_OP_REXTA: c.has_addr = 1'b0;
		default: c.ok = 1'b0;
		endcase
		if (pw == 2'h3) begin
			c.ok = 1'b0;
		end
		return c;
	endfunction

	function automatic logic [7:0] sfrl_cx_base(input logic [1:0] pw);
		return (pw == SFRL_PW_QUAD) ? SFRL_CX_QUAD : (pw == SFRL_PW_DUAL) ? SFRL_CX_DUAL : SFRL_CX_EXT;
	endfunction

	// clock index of the last address clock; dummy clocks follow it
	function automatic logic [7:0] sfrl_cx(input sfrl_cmd_t c, input logic [1:0] pw,
		input logic a4);
		logic [7:0] ab;
		ab = a4 ? SFRL_ABITS_4B : SFRL_ABITS_3B;
		if (!c.has_addr) begin
			ab = 8'h00;
		end
		return sfrl_cx_base(pw) + (ab >> ({1'b0, c.aw} + {2'h0, c.dtr}));
	endfunction

	function automatic logic [3:0] sfrl_lane_mask(input logic [1:0] w);
		return (w == 2'h2) ? 4'hf : (w == 2'h1) ? 4'h3 : 4'h1;
	endfunction

	function automatic logic [3:0] sfrl_lane_bits(input logic [3:0] t, input logic [1:0] w);
		return (w == 2'h2) ? t : (w == 2'h1) ? {2'h0, t[3:2]} : {3'h0, t[3]};
	endfunction

endpackage

//--- logic/sfrl_sclk.sv
// serial clock divider with edge and mid-half event pulses
// assumes i_run stays high until the caller has seen the clock return low
`timescale 1ns/10ps
module sfrl_sclk import sfrl_pkg::*; #(
	parameter int HALF = SFRL_HALF_CYC
) (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_run,
	output logic o_sclk,
	output logic o_rise,
	output logic o_fall,
	output logic o_mid
);
	logic [7:0] tmr_q, tmr_d;
	logic sclk_q, sclk_d, rise_q, rise_d, fall_q, fall_d, mid_q, mid_d, tick;

	// ----------------------------------------
	// divider
	// ----------------------------------------
	always_comb begin
		tick = i_run && (tmr_q == 8'(HALF - 1));
		tmr_d = (!i_run || tick) ? 8'h00 : tmr_q + 8'h01;
		sclk_d = tick ? ~sclk_q : (i_run & sclk_q);
		rise_d = tick & ~sclk_q;
		fall_d = tick & sclk_q;
		// lanes change mid-half so both clock edges see settled data
		mid_d = i_run && (tmr_q == 8'(HALF / 2 - 1));
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			tmr_q <= 8'h00;
			sclk_q <= 1'b0;
			rise_q <= 1'b0;
			fall_q <= 1'b0;
			mid_q <= 1'b0;
		end else begin
			tmr_q <= tmr_d;
			sclk_q <= sclk_d;
			rise_q <= rise_d;
			fall_q <= fall_d;
			mid_q <= mid_d;
		end
	end

	assign o_sclk = sclk_q;
	assign o_rise = rise_q;
	assign o_fall = fall_q;
	assign o_mid = mid_q;
endmodule

//--- logic/sfrl_apb.sv
// apb slave with the control, address, status and receive registers
// assumes a well-behaved apb master; one wait state on every access
`timescale 1ns/10ps
module sfrl_apb import sfrl_pkg::*; (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire sfrl_apb_req_t i_req,
	input wire sfrl_stat_t i_stat,
	input wire logic [31:0] i_rx,
	output sfrl_apb_rsp_t o_rsp,
	output sfrl_order_t o_order,
	output logic o_go
);
	logic [31:0] ctrl_q, ctrl_d, addr_q, addr_d;
	sfrl_apb_rsp_t rsp_q, rsp_d;
	logic go_q, go_d, acc, take, known;

	// ----------------------------------------
	// access decode
	// ----------------------------------------
	always_comb begin
		acc = i_req.psel & i_req.penable;
		take = acc & rsp_q.pready;
		known = (i_req.paddr == SFRL_OFF_CTRL) || (i_req.paddr == SFRL_OFF_ADDR) ||
			(i_req.paddr == SFRL_OFF_STAT) || (i_req.paddr == SFRL_OFF_RX);
		rsp_d = '{pready: acc & ~rsp_q.pready, pslverr: 1'b0, prdata: 32'h0000_0000};
		if (acc && !rsp_q.pready) begin
			rsp_d.pslverr = ~known;
			if (!i_req.pwrite) begin
				case (i_req.paddr)
				SFRL_OFF_CTRL: rsp_d.prdata = {1'b0, ctrl_q[30:0]};
				SFRL_OFF_ADDR: rsp_d.prdata = addr_q;
				SFRL_OFF_STAT: rsp_d.prdata = {16'h0000, i_stat.cx, 5'h00,
					i_stat.refused, i_stat.done, i_stat.busy};
				SFRL_OFF_RX: rsp_d.prdata = i_rx;
				default: rsp_d.prdata = 32'h0000_0000;
				endcase
			end
		end
		ctrl_d = ctrl_q;
		addr_d = addr_q;
		go_d = 1'b0;
		if (take && i_req.pwrite) begin
			if (i_req.paddr == SFRL_OFF_CTRL) begin
				ctrl_d = i_req.pwdata;
				// a start while busy is dropped, not queued
				go_d = i_req.pwdata[SFRL_CTRL_GO_BIT] & ~i_stat.busy;
			end
			if (i_req.paddr == SFRL_OFF_ADDR) begin
				addr_d = i_req.pwdata;
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ctrl_q <= SFRL_CTRL_RST;
			addr_q <= SFRL_ADDR_RST;
			rsp_q <= '0;
			go_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			addr_q <= addr_d;
			rsp_q <= rsp_d;
			go_q <= go_d;
		end
	end

	assign o_rsp = rsp_q;
	assign o_go = go_q;
	assign o_order = '{op: ctrl_q[SFRL_CTRL_OP_LSB +: 8], pw: ctrl_q[SFRL_CTRL_PW_LSB +: 2],
		a4: ctrl_q[SFRL_CTRL_A4_BIT], dummy: ctrl_q[SFRL_CTRL_DUM_LSB +: 4],
		nb: ctrl_q[SFRL_CTRL_NB_LSB +: 3], addr: addr_q};
endmodule

//--- logic/sfrl_host.sv
// host controller that runs read and latch-command frames on a serial flash
// assumes one flash device on the lanes and an apb master for the registers
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/10ps
module sfrl_host import sfrl_pkg::*; #(
	parameter int HALF = SFRL_HALF_CYC,
	parameter int CS_HIGH = SFRL_CS_HIGH_CYC
) (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	output logic o_cs_n,
	output logic o_sclk,
	input wire logic [3:0] i_lane_in,
	output logic [3:0] o_lane_out,
	output logic [3:0] o_lane_oe
);
	typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_RUN, ST_STOP, ST_GAP} sfrl_st_t;
	typedef enum logic [2:0] {PH_OP, PH_ADDR, PH_DUMMY, PH_DATA, PH_END} sfrl_ph_t;

	sfrl_apb_req_t req;
	sfrl_apb_rsp_t rsp;
	sfrl_order_t ord;
	sfrl_stat_t stat;
	sfrl_cmd_t dec, cmd_q, cmd_d;
	sfrl_st_t st_q, st_d;
	sfrl_ph_t ph_q, ph_d, nxt;
	logic go, sclk, rise, fall, mid, run, latch, quad_use;
	logic [3:0] sync1_q, sync2_q;
	logic [39:0] tx_q, tx_d;
	logic [31:0] rx_q, rx_d;
	logic [6:0] beats_q, beats_d, nbeats;
	logic [7:0] cnt_q, cnt_d, cx_q, cx_d;
	logic [1:0] pw_q, pw_d, advw_q, advw_d, wcur, wnew;
	logic [3:0] dum_q, dum_d;
	logic [2:0] nb_q, nb_d;
	logic adv_q, adv_d, done_q, done_d, ref_q, ref_d, cs_n_q, cs_n_d;
	logic [3:0] lout_q, lout_d, loe_q, loe_d;

	// ----------------------------------------
	// register side
	// ----------------------------------------
	assign req = '{psel: i_psel, penable: i_penable, pwrite: i_pwrite,
		paddr: i_paddr, pwdata: i_pwdata};
	assign stat = '{busy: (st_q != ST_IDLE), done: done_q, refused: ref_q, cx: cx_q};

	sfrl_apb u_apb (
		.i_mclk(i_mclk),
		.i_reset_n(i_reset_n),
		.i_req(req),
		.i_stat(stat),
		.i_rx(rx_q),
		.o_rsp(rsp),
		.o_order(ord),
		.o_go(go)
	);

	assign o_prdata = rsp.prdata;
	assign o_pready = rsp.pready;
	assign o_pslverr = rsp.pslverr;

	// ----------------------------------------
	// serial clock
	// ----------------------------------------
	assign run = (st_q == ST_RUN) || ((st_q == ST_STOP) && sclk);

	sfrl_sclk #(.HALF(HALF)) u_sclk (
		.i_mclk(i_mclk),
		.i_reset_n(i_reset_n),
		.i_run(run),
		.o_sclk(sclk),
		.o_rise(rise),
		.o_fall(fall),
		.o_mid(mid)
	);

	assign o_sclk = sclk;

	// ----------------------------------------
	// lane input synchroniser
	// ----------------------------------------
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sync1_q <= 4'h0;
			sync2_q <= 4'h0;
		end else begin
			sync1_q <= i_lane_in;
			sync2_q <= sync1_q;
		end
	end

	// ----------------------------------------
	// frame sequencer
	// ----------------------------------------
	always_comb begin
		dec = sfrl_decode(ord.op, ord.pw);
		case (ph_q)
		PH_OP: wcur = pw_q;
		PH_ADDR: wcur = cmd_q.aw;
		PH_DATA: wcur = cmd_q.dw;
		default: wcur = 2'h0;
		endcase
		// double rate applies to address and data only; opcode stays single rate
		latch = rise || (fall && cmd_q.dtr && ((ph_q == PH_ADDR) || (ph_q == PH_DATA)));
		case (ph_q)
		PH_OP: nxt = cmd_q.has_addr ? PH_ADDR : (nb_q != 3'h0) ? PH_DATA : PH_END;
		PH_ADDR: nxt = (dum_q != 4'h0) ? PH_DUMMY : (nb_q != 3'h0) ? PH_DATA : PH_END;
		PH_DUMMY: nxt = (nb_q != 3'h0) ? PH_DATA : PH_END;
		default: nxt = PH_END;
		endcase
		case (nxt)
		PH_ADDR: nbeats = 7'((cx_q - sfrl_cx_base(pw_q)) << cmd_q.dtr);
		PH_DUMMY: nbeats = {3'h0, dum_q};
		PH_DATA: nbeats = 7'(({4'h0, nb_q} << 3) >> cmd_q.dw);
		default: nbeats = 7'h00;
		endcase
	end

	always_comb begin
		st_d = st_q;
		ph_d = ph_q;
		beats_d = beats_q;
		tx_d = tx_q;
		rx_d = rx_q;
		adv_d = adv_q;
		advw_d = advw_q;
		cmd_d = cmd_q;
		pw_d = pw_q;
		dum_d = dum_q;
		nb_d = nb_q;
		cx_d = cx_q;
		cnt_d = cnt_q;
		done_d = done_q;
		ref_d = ref_q;
		cs_n_d = cs_n_q;
		case (st_q)
		ST_IDLE: begin
			if (go) begin
				done_d = 1'b0;
				ref_d = 1'b0;
				if (!dec.ok) begin
					// wrong protocol for the opcode: no frame at all
					ref_d = 1'b1;
					done_d = 1'b1;
				end else begin
					cmd_d = dec;
					pw_d = ord.pw;
					dum_d = dec.has_addr ? ord.dummy : 4'h0;
					nb_d = (ord.op == SFRL_OP_WEN || ord.op == SFRL_OP_WDIS) ? 3'h0 : ord.nb;
					cx_d = sfrl_cx(dec, ord.pw, ord.a4);
					tx_d = ord.a4 ? {ord.op, ord.addr} : {ord.op, ord.addr[23:0], 8'h00};
					if (ord.op == SFRL_OP_QWORD) begin
						tx_d[ord.a4 ? 0 : 8] = 1'b0;
					end
					ph_d = PH_OP;
					beats_d = 7'(8 >> ord.pw);
					adv_d = 1'b0;
					rx_d = 32'h0000_0000;
					cs_n_d = 1'b0;
					cnt_d = 8'(HALF - 1);
					st_d = ST_SETUP;
				end
			end
		end
		ST_SETUP: begin
			if (cnt_q == 8'h00) begin
				st_d = ST_RUN;
			end else begin
				cnt_d = cnt_q - 8'h01;
			end
		end
		ST_RUN: begin
			if (mid && adv_q) begin
				tx_d = tx_q << (6'h01 << advw_q);
				adv_d = 1'b0;
			end
			if (latch && (ph_q == PH_DUMMY) && !rise) begin
				beats_d = beats_q;
			end else if (latch) begin
				if (ph_q == PH_DATA) begin
					case (cmd_q.dw)
					2'h2: rx_d = {rx_q[27:0], sync2_q};
					2'h1: rx_d = {rx_q[29:0], sync2_q[1:0]};
					default: rx_d = {rx_q[30:0], sync2_q[1]};
					endcase
				end
				if ((ph_q == PH_OP) || (ph_q == PH_ADDR)) begin
					adv_d = 1'b1;
					advw_d = wcur;
				end
				beats_d = beats_q - 7'h01;
				if (beats_q == 7'h01) begin
					ph_d = nxt;
					beats_d = nbeats;
					if (nxt == PH_END) begin
						st_d = ST_STOP;
					end
				end
			end
		end
		ST_STOP: begin
			if (!sclk) begin
				// select rises once sclk is back low after the last latched bit
				cs_n_d = 1'b1;
				cnt_d = 8'(CS_HIGH - 1);
				st_d = ST_GAP;
			end
		end
		ST_GAP: begin
			if (cnt_q == 8'h00) begin
				done_d = 1'b1;
				st_d = ST_IDLE;
			end else begin
				cnt_d = cnt_q - 8'h01;
			end
		end
		default: st_d = ST_IDLE;
		endcase
	end

	// ----------------------------------------
	// lane drivers
	// ----------------------------------------
	always_comb begin
		wnew = (ph_d == PH_OP) ? pw_d : cmd_d.aw;
		quad_use = (pw_d == SFRL_PW_QUAD) || (cmd_d.aw == 2'h2) || (cmd_d.dw == 2'h2);
		lout_d = 4'h0;
		loe_d = 4'h0;
		if (!cs_n_d) begin
			if (!quad_use) begin
				// upper lanes double as write protect and hold; keep them inactive
				lout_d[3:2] = 2'h3;
				loe_d[3:2] = 2'h3;
			end
			if ((ph_d == PH_OP) || (ph_d == PH_ADDR)) begin
				lout_d = lout_d | sfrl_lane_bits(tx_d[39:36], wnew);
				loe_d = loe_d | sfrl_lane_mask(wnew);
			end
		end
	end

	// ----------------------------------------
	// state registers
	// ----------------------------------------
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			st_q <= ST_IDLE;
			ph_q <= PH_END;
			beats_q <= 7'h00;
			tx_q <= 40'h00_0000_0000;
			rx_q <= 32'h0000_0000;
			adv_q <= 1'b0;
			advw_q <= 2'h0;
			cmd_q <= '0;
			pw_q <= 2'h0;
			dum_q <= 4'h0;
			nb_q <= 3'h0;
			cx_q <= 8'h00;
			cnt_q <= 8'h00;
			done_q <= 1'b0;
			ref_q <= 1'b0;
			cs_n_q <= 1'b1;
			lout_q <= 4'h0;
			loe_q <= 4'h0;
		end else begin
			st_q <= st_d;
			ph_q <= ph_d;
			beats_q <= beats_d;
			tx_q <= tx_d;
			rx_q <= rx_d;
			adv_q <= adv_d;
			advw_q <= advw_d;
			cmd_q <= cmd_d;
			pw_q <= pw_d;
			dum_q <= dum_d;
			nb_q <= nb_d;
			cx_q <= cx_d;
			cnt_q <= cnt_d;
			done_q <= done_d;
			ref_q <= ref_d;
			cs_n_q <= cs_n_d;
			lout_q <= lout_d;
			loe_q <= loe_d;
		end
	end

	assign o_cs_n = cs_n_q;
	assign o_lane_out = lout_q;
	assign o_lane_oe = loe_q;
endmodule

//--- verif/sfrl_flash_model.sv
// behavioural flash device for the host controller bench, extended protocol only
// assumes the bench resolves each lane from host drive enables and this model's levels
`timescale 1ns/10ps
module sfrl_flash_model #(
	parameter logic [15:0] NVCFG = 16'hffa5,
	parameter logic [7:0] VCFG = 8'hfb
) (
	input wire logic i_cs_n,
	input wire logic i_sclk,
	input wire logic [3:0] i_lane,
	output logic [3:0] o_lane = 4'h5
);
	logic [7:0] op_q = 8'h00;
	logic [23:0] a_q = 24'h0;
	logic wel_q = 1'b0;
	int k = 0;

	// ----------------------------------------
	// read data per byte index
	// ----------------------------------------
	function automatic logic [7:0] rd_byte(input int b);
		case (op_q)
		8'h05, 8'h70: return {6'h0, wel_q, 1'b0};
		8'hb5: return (b == 0) ? NVCFG[7:0] : (b == 1) ? NVCFG[15:8] : 8'h00;
		8'h85, 8'h65, 8'hc8: return VCFG;
		8'h03: return a_q[7:0] + b[7:0];
		default: return 8'h00;
		endcase
	endfunction

	always @(posedge i_sclk) begin
		if (!i_cs_n) begin
			if (k < 8) op_q = {op_q[6:0], i_lane[0]};
			else if (k < 32) a_q = {a_q[22:0], i_lane[0]};
			k = k + 1;
		end
	end

	// latch only changes when select rises right after the eighth opcode bit
	always @(posedge i_cs_n) begin
		if (k == 8 && op_q == 8'h06) wel_q = 1'b1;
		if (k == 8 && op_q == 8'h04) wel_q = 1'b0;
		k = 0;
	end

	// lanes show the inverse of their last level outside the data bytes; during them only lane 1 changes, the rest hold
	always @(negedge i_sclk or posedge i_cs_n) begin
		int n;
		logic [7:0] v;
		n = k - ((op_q == 8'h03) ? 32 : 8);
		v = rd_byte(n / 8);
		if (i_cs_n || k < 8 || n < 0) o_lane <= ~o_lane;
		else o_lane[1] <= v[7 - n % 8];
	end
endmodule

//--- verif/sfrl_host_chk.sv
// port checker for the serial flash host controller
// assumes the bound instance runs with the same half period and select gap
`timescale 1ns/10ps
module sfrl_host_chk import sfrl_pkg::*; #(
	parameter int HALF = SFRL_HALF_CYC,
	parameter int CS_HIGH = SFRL_CS_HIGH_CYC
) (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic o_cs_n,
	input wire logic o_sclk,
	input wire logic [3:0] o_lane_out,
	input wire logic [3:0] o_lane_oe
);
	logic [7:0] hi_q;
	logic [7:0] gap_q;
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			hi_q <= 8'h00;
			gap_q <= 8'hff;
		end else begin
			hi_q <= o_sclk ? hi_q + 8'h01 : 8'h00;
			gap_q <= !o_cs_n ? 8'h00 : (gap_q == 8'hff) ? gap_q : gap_q + 8'h01;
		end
	end
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);

	// ----------------------------------------
	// link framing
	// ----------------------------------------
	property p_sclk_idle; o_cs_n |-> !o_sclk; endproperty
	a_sclk_idle: assert property (p_sclk_idle) else $error("sclk moves while deselected");
	property p_oe_idle; o_cs_n |-> (o_lane_oe == 4'h0); endproperty
	a_oe_idle: assert property (p_oe_idle) else $error("lanes driven while deselected");
	property p_half; $fell(o_sclk) |-> (hi_q == HALF); endproperty
	a_half: assert property (p_half) else $error("sclk high time wrong");
	property p_cs_gap; $fell(o_cs_n) |-> (gap_q >= CS_HIGH); endproperty
	a_cs_gap: assert property (p_cs_gap) else $error("select gap too short");
	property p_first_rise; $fell(o_cs_n) |-> !o_sclk [*6]; endproperty
	a_first_rise: assert property (p_first_rise) else $error("first sclk rise too early");
	property p_sclk_down; $rose(o_cs_n) |-> !$past(o_sclk); endproperty
	a_sclk_down: assert property (p_sclk_down) else $error("select rose with sclk high");
	property p_lane_hold; (!o_cs_n && $rose(o_sclk)) |-> $stable(o_lane_out); endproperty
	a_lane_hold: assert property (p_lane_hold) else $error("lane moved at sclk rise");

	// ----------------------------------------
	// register bus
	// ----------------------------------------
	property p_wait; (i_psel && !i_penable) |=> !o_pready ##1 o_pready; endproperty
	a_wait: assert property (p_wait) else $error("apb wait state count wrong");
	property p_err; o_pslverr |-> o_pready; endproperty
	a_err: assert property (p_err) else $error("slverr outside ready");
	property p_rdata; !o_pready |-> (o_prdata == 32'h0); endproperty
	a_rdata: assert property (p_rdata) else $error("read data outside ready");
	property p_unmap; (o_pready && (i_paddr[1:0] != 2'h0 || i_paddr > 8'h0c)) |-> o_pslverr;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped access not refused");

	c_frame: cover property ($fell(o_cs_n));
	c_err: cover property (o_pslverr);
	c_end: cover property ($rose(o_cs_n));
endmodule

bind sfrl_host sfrl_host_chk #(.HALF(HALF), .CS_HIGH(CS_HIGH)) sfrl_host_chk_inst (
	.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_psel(i_psel), .i_penable(i_penable),
	.i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
	.o_cs_n(o_cs_n), .o_sclk(o_sclk), .o_lane_out(o_lane_out), .o_lane_oe(o_lane_oe)
);

//--- verif/testbench.sv
// self-checking bench for the serial flash host controller
// assumes the flash model answers in extended protocol; other protocols only count clocks
`timescale 1ns/10ps
module testbench import sfrl_pkg::*;;
	typedef struct packed {
		logic [7:0] op;
		logic [1:0] pw;
		logic a4;
		logic [7:0] cx;
		logic rf;
	} sfrl_row_t;
	logic mclk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, st, rx;
	logic pready, pslverr, er, cs_n, sclk;
	logic [3:0] lane_in, lane_out, lane_oe, m_lane;
	logic [3:0] dm = 4'h0;
	int miscompares = 0, n_compared = 0, rises = 0, cyc = 0;
	sfrl_row_t rows [18] = '{'{8'h03, 2'h0, 1'b0, 8'h1f, 1'b0}, '{8'h13, 2'h2, 1'b1, 8'h09, 1'b0},
		'{8'h3b, 2'h1, 1'b0, 8'h0f, 1'b0}, '{8'hbb, 2'h0, 1'b0, 8'h13, 1'b0},
		'{8'hbc, 2'h1, 1'b1, 8'h13, 1'b0}, '{8'heb, 2'h0, 1'b0, 8'h0d, 1'b0},
		'{8'hec, 2'h2, 1'b1, 8'h09, 1'b0}, '{8'he7, 2'h2, 1'b0, 8'h07, 1'b0},
		'{8'h0d, 2'h0, 1'b0, 8'h13, 1'b0}, '{8'h0e, 2'h1, 1'b1, 8'h0b, 1'b0},
		'{8'h6d, 2'h2, 1'b0, 8'h04, 1'b0}, '{8'hbd, 2'h0, 1'b0, 8'h0d, 1'b0},
		'{8'hbe, 2'h1, 1'b1, 8'h07, 1'b0}, '{8'hed, 2'h0, 1'b0, 8'h0a, 1'b0},
		'{8'hee, 2'h2, 1'b1, 8'h05, 1'b0}, '{8'h3b, 2'h2, 1'b0, 8'h00, 1'b1},
		'{8'he7, 2'h1, 1'b0, 8'h00, 1'b1}, '{8'h99, 2'h0, 1'b0, 8'h00, 1'b1}};

	// host drive wins where enabled, the model's level elsewhere
	assign lane_in = (lane_oe & lane_out) | (~lane_oe & m_lane);
	sfrl_host #(.HALF(4), .CS_HIGH(8)) sfrl_host_inst (.i_mclk(mclk), .i_reset_n(reset_n),
		.i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.o_cs_n(cs_n), .o_sclk(sclk), .i_lane_in(lane_in), .o_lane_out(lane_out),
		.o_lane_oe(lane_oe));
	sfrl_flash_model sfrl_flash_model_inst (.i_cs_n(cs_n), .i_sclk(sclk), .i_lane(lane_in),
		.o_lane(m_lane));

	initial begin
		forever #2.5 mclk = ~mclk;
	end
	always @(posedge sclk) rises = rises + 1;
	always @(negedge cs_n) rises = 0;
	always @(posedge mclk) begin
		cyc = cyc + 1;
		if (cyc == 60000) begin
			miscompares = miscompares + 1;
			print_verdict();
		end
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_compared = n_compared + 1;
		if (got !== exp) begin
			miscompares = miscompares + 1;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic run(input logic [7:0] op, input logic [1:0] pw, input logic a4,
		input logic [2:0] nb, input logic [31:0] a);
		apb(1'b1, SFRL_OFF_ADDR, a);
		apb(1'b1, SFRL_OFF_CTRL, {1'b1, 12'h0, nb, dm, 1'b0, a4, pw, op});
		repeat (2) @(posedge mclk);
		do apb(1'b0, SFRL_OFF_STAT, 32'h0); while (!(rd[1] === 1'b1 && rd[0] === 1'b0));
		st = rd;
		apb(1'b0, SFRL_OFF_RX, 32'h0);
		rx = rd;
	endtask
	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge mclk);
		reset_n <= 1'b1;
		@(posedge mclk);
		apb(1'b0, SFRL_OFF_CTRL, 32'h0);
		chk("ctrl reset", rd, SFRL_CTRL_RST);
		apb(1'b0, 8'h10, 32'h0);
		chk("slverr", {31'h0, er}, 32'h1);
		for (int i = 0; i < 18; i++) begin
			run(rows[i].op, rows[i].pw, rows[i].a4, 3'h0, 32'h0);
			chk("refused", {31'h0, st[2]}, {31'h0, rows[i].rf});
			if (!rows[i].rf) begin
				chk("cx", {24'h0, st[15:8]}, {24'h0, rows[i].cx});
				chk("clocks", rises, rows[i].cx + 32'h1);
			end
		end
		run(8'h06, 2'h0, 1'b0, 3'h2, 32'h0);
		chk("wen clocks", rises, 32'h8);
		run(8'h05, 2'h0, 1'b0, 3'h2, 32'h0);
		chk("status", rx, 32'h0202);
		run(8'h04, 2'h0, 1'b0, 3'h0, 32'h0);
		run(8'h70, 2'h0, 1'b0, 3'h1, 32'h0);
		chk("flags", rx, 32'h0);
		run(8'hb5, 2'h0, 1'b0, 3'h4, 32'h0);
		chk("nvcfg", rx, 32'ha5ff0000);
		run(8'h85, 2'h0, 1'b0, 3'h3, 32'h0);
		chk("vcfg", rx, 32'h00fbfbfb);
		run(8'h03, 2'h0, 1'b0, 3'h4, 32'h10);
		chk("memory", rx, 32'h10111213);
		chk("read clocks", rises, 32'h40);
		run(8'h6b, 2'h2, 1'b0, 3'h1, 32'h0);
		chk("quad data clocks", rises, 32'ha);
		dm = 4'h8;
		run(8'h0b, 2'h0, 1'b0, 3'h1, 32'h0);
		chk("dummy clocks", rises, 32'h30);
		apb(1'b1, SFRL_OFF_CTRL, 32'h8004_0003);
		repeat (30) @(posedge mclk);
		reset_n <= 1'b0;
		repeat (2) @(posedge mclk);
		chk("cs idle", {31'h0, cs_n}, 32'h1);
		chk("oe idle", {28'h0, lane_oe}, 32'h0);
		reset_n <= 1'b1;
		@(posedge mclk);
		apb(1'b0, SFRL_OFF_ADDR, 32'h0);
		chk("addr reset", rd, SFRL_ADDR_RST);
		print_verdict();
	end
endmodule
